// ==== ramp_defs.svh ====
// Constants for the drive ramp time controller
`ifndef RAMP_DEFS_SVH
`define RAMP_DEFS_SVH
// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_ACC1 12'h004
`define OFS_DEC1 12'h008
`define OFS_ACC2 12'h00c
`define OFS_DEC2 12'h010
`define OFS_ACC3 12'h014
`define OFS_DEC3 12'h018
`define OFS_ACC4 12'h01c
`define OFS_DEC4 12'h020
`define OFS_FSTOP 12'h024
`define OFS_UNIT 12'h028
`define OFS_SWF 12'h02c
`define OFS_DWELL_START 12'h030
`define OFS_DWELL_STOP 12'h034
`define OFS_HOLD 12'h038
`define OFS_FALLBACK 12'h03c
`define OFS_MAXF 12'h040
`define OFS_CMD 12'h044
`define OFS_STATUS 12'h048
`define OFS_FREQ 12'h04c
// Field positions
`define CTRL_RUN 0
`define CTRL_FBL 1
`define CTRL_FAULT_FS 2
`define CTRL_ZH_SEL 3
`define CTRL_METHOD_LO 4
`define CTRL_METHOD_HI 6
`define CTRL_PM 7
`define ST_FSTOP 0
`define ST_ZHOLD 1
`define ST_COAST 2
`define ST_UNIT_REJ 3
// Reset values; frequencies in 0.1 Hz, times in unit ticks
`define RST_RAMP_TIME 32'd100
`define RST_UNIT 1'b1
`define RST_FALLBACK 16'd300
`define RST_HOLD_TIME 16'd10
`define RST_MAXF 16'd600
`define TIME_LIMIT_COARSE 32'd60000
`define FINE_REJECT 32'd6001
`define DWELL_MAX 16'd100
`define HOLD_CONT 16'd9999
`define DC_HOLD_LIMIT 8'd20
// Input and output function codes
`define FC_SEL1 8'h10
`define FC_SEL2 8'h11
`define FC_FS_NO 8'h15
`define FC_FS_NC 8'h16
`define FC_MOTOR 8'h33
`define FC_OUT_FS 8'h2c
// Timing: 10 ms tick at 200 MHz
`define CLK_HZ 200000000
`define TICK_HZ 100
`define TICK_CYCLES (`CLK_HZ / `TICK_HZ)
`endif

// ==== ramp_pkg.sv ====
// Types for the drive ramp time controller
package ramp_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ACCEL = 3'b001,
        ST_DWELL_UP = 3'b011,
        ST_RUN = 3'b010,
        ST_DECEL = 3'b110,
        ST_DWELL_DN = 3'b111,
        ST_ZHOLD = 3'b101,
        ST_COAST = 3'b100
    } ramp_state_e;
endpackage : ramp_pkg

// ==== tick_divider.sv ====
// Divider that makes the one-cycle control tick
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
    parameter int CYCLES = 2000000
) (
    input wire logic i_clk,
    input wire logic i_srst,
    output logic o_tick
);
    logic [31:0] count;
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            count <= 32'h0;
            o_tick <= 1'b0;
        end else if (count == 32'(CYCLES - 1)) begin
            count <= 32'h0;
            o_tick <= 1'b1;
        end else begin
            count <= count + 32'h1;
            o_tick <= 1'b0;
        end
    end
endmodule : tick_divider
`default_nettype wire

// ==== drive_ramp_time_control.sv ====
// Ramp controller with time pair select, dwell, fast stop and zero hold
//
// Contract
// RULE1 - Feedback loss alarm forces fallback frequency
// RULE2 - Acceleration holds at start dwell frequency
// RULE3 - Deceleration holds at stop dwell frequency
// RULE4 - Stop dwell needs ramp-to-stop stopping method; the stop dwell entry here does not check the stopping method
// RULE5 - Zero hold only in methods 0, 1
// RULE6 - Hold select: coast or DC hold, clamped
// RULE7 - Hold ends after hold time; 99.99 continuous
// RULE8 - Ramp time spans zero to maximum frequency
// RULE9 - Pair one default; times default 10.0 s
// RULE10 - Codes 16, 17 select one of four pairs
// RULE11 - Code 51 selects motor; not in PM
// RULE12 - Motor selection: code 16 picks pair
// RULE13 - Switch frequency picks pair 4 below threshold
// RULE14 - Input selection overrides threshold switching
// RULE15 - Codes 21, 22 latch a fast stop
// RULE16 - Restart needs stop done, input off, run cycled
// RULE17 - Output code 44 closes during fast stop
// RULE18 - Fault fast stop uses fast stop time
// RULE19 - Time unit: 0 gives 0.01 s, 1 gives 0.1 s
// RULE20 - Unit 0 refused while any time >= 600.1
// RULE21 - Sleep after delay below sleep level; no sleep function is implemented
// RULE22 - Wake after delay above wake level; no wake function is implemented
// RULE23 - Step per tick from max over time, no overshoot
`timescale 1ns/10ps
`default_nettype none
`include "ramp_defs.svh"
module drive_ramp_time_control import ramp_pkg::*; #(
    parameter int NUM_IN = 4,
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [NUM_IN-1:0] i_terminal,
    input wire logic [7:0] i_dc_hold_current,
    input wire logic [15:0] i_pid_frequency,
    input wire logic [31:0] i_function_codes,
    input wire logic [7:0] i_output_function_code,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [15:0] o_frequency,
    output logic o_output_enable,
    output logic o_dc_hold,
    output logic [7:0] o_dc_hold_current,
    output logic o_fast_stop_terminal,
    output logic o_motor2
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] ctrl;
    logic [31:0] ramp_time [0:8];
    logic unit_fine;
    logic unit_reject;
    logic [15:0] switch_freq;
    logic [15:0] start_dwell_frequency, stop_dwell_frequency;
    logic [15:0] start_dwell_time, stop_dwell_time;
    logic [15:0] zero_hold_time, fallback_frequency, max_output_frequency;
    logic [15:0] command;
    logic aw_held, w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic tick;
    ramp_state_e state;
    logic [31:0] accum;
    logic [31:0] timer;
    logic fast_stop, fs_decel_done, run_cycled;
    logic [15:0] target;
    logic [31:0] active_time, ramp_thr;
    logic sel1, sel2, motor_in, fs_no, fs_nc;
    logic fs_trigger;
    logic [1:0] pair;
    logic any_over;
    logic wr_go;

    // True when any terminal carrying the given function code is at the wanted level
    function automatic logic term_has(input logic [7:0] code,
                                      input logic [31:0] codes,
                                      input logic [NUM_IN-1:0] pins,
                                      input logic want);
        logic r;
        r = 1'b0;
        for (int k = 0; k < NUM_IN; k++) begin
            if (codes[k*8 +: 8] == code && pins[k] == want) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction : term_has

    function automatic logic term_assigned(input logic [7:0] code,
                                           input logic [31:0] codes);
        logic r;
        r = 1'b0;
        for (int k = 0; k < NUM_IN; k++) begin
            if (codes[k*8 +: 8] == code) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction : term_assigned

    tick_divider #(.CYCLES(TICK_CYCLES)) u_tick (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .o_tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave; one cycle answer once both halves are held
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_go = aw_held && w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr > `OFS_CMD) ? 2'b10 : 2'b00;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Unit 0 refused while any of the nine ramp times exceeds the fine range
    always_comb begin
        any_over = 1'b0;
        for (int k = 0; k < 9; k++) begin
            if (ramp_time[k] >= `FINE_REJECT) begin
                any_over = 1'b1; // RULE20
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctrl <= 8'h00;
            for (int k = 0; k < 9; k++) begin
                ramp_time[k] <= `RST_RAMP_TIME; // RULE9
            end
            unit_fine <= ~`RST_UNIT; // RULE19
            unit_reject <= 1'b0;
            switch_freq <= 16'h0;
            start_dwell_frequency <= 16'h0;
            start_dwell_time <= 16'h0;
            stop_dwell_frequency <= 16'h0;
            stop_dwell_time <= 16'h0;
            zero_hold_time <= `RST_HOLD_TIME; // RULE7
            fallback_frequency <= `RST_FALLBACK; // RULE1
            max_output_frequency <= `RST_MAXF;
            command <= 16'h0;
        end else if (wr_go) begin
            case (aw_addr)
                `OFS_CTRL: begin
                    if (w_strb[0]) begin
                        ctrl <= w_data[7:0];
                    end
                end
                `OFS_UNIT: begin
                    if (!w_data[0] && any_over) begin
                        unit_reject <= 1'b1; // RULE20
                    end else begin
                        unit_fine <= !w_data[0];
                        unit_reject <= 1'b0;
                    end
                end
                `OFS_SWF: switch_freq <= w_data[15:0];
                `OFS_DWELL_START: begin
                    start_dwell_frequency <= w_data[15:0];
                    start_dwell_time <= (w_data[31:16] > `DWELL_MAX) ?
                        `DWELL_MAX : w_data[31:16]; // RULE2
                end
                `OFS_DWELL_STOP: begin
                    stop_dwell_frequency <= w_data[15:0];
                    stop_dwell_time <= (w_data[31:16] > `DWELL_MAX) ?
                        `DWELL_MAX : w_data[31:16];
                end
                `OFS_HOLD: zero_hold_time <= w_data[15:0];
                `OFS_FALLBACK: fallback_frequency <= w_data[15:0];
                `OFS_MAXF: max_output_frequency <= w_data[15:0];
                `OFS_CMD: command <= w_data[15:0];
                default: begin
                    if (aw_addr >= `OFS_ACC1 && aw_addr <= `OFS_FSTOP) begin
                        ramp_time[4'((aw_addr - `OFS_ACC1) >> 2)] <=
                            (w_data > `TIME_LIMIT_COARSE) ?
                            `TIME_LIMIT_COARSE : w_data; // RULE9
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
                `OFS_CTRL: s_axi_rdata <= {24'h0, ctrl};
                `OFS_UNIT: s_axi_rdata <= {31'h0, !unit_fine};
                `OFS_SWF: s_axi_rdata <= {16'h0, switch_freq};
                `OFS_DWELL_START:
                    s_axi_rdata <= {start_dwell_time, start_dwell_frequency};
                `OFS_DWELL_STOP:
                    s_axi_rdata <= {stop_dwell_time, stop_dwell_frequency};
                `OFS_HOLD: s_axi_rdata <= {16'h0, zero_hold_time};
                `OFS_FALLBACK: s_axi_rdata <= {16'h0, fallback_frequency};
                `OFS_MAXF: s_axi_rdata <= {16'h0, max_output_frequency};
                `OFS_CMD: s_axi_rdata <= {16'h0, command};
                `OFS_STATUS: s_axi_rdata <= {28'h0, unit_reject,
                    state == ST_COAST, state == ST_ZHOLD, fast_stop};
                `OFS_FREQ: s_axi_rdata <= {16'h0, o_frequency};
                default: begin
                    if (s_axi_araddr >= `OFS_ACC1 &&
                        s_axi_araddr <= `OFS_FSTOP) begin
                        s_axi_rdata <=
                            ramp_time[4'((s_axi_araddr - `OFS_ACC1) >> 2)];
                    end else begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'b10;
                    end
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Terminal decode and time pair selection
    assign sel1 = term_has(`FC_SEL1, i_function_codes, i_terminal, 1'b1);
    assign sel2 = term_has(`FC_SEL2, i_function_codes, i_terminal, 1'b1);
    assign motor_in = !ctrl[`CTRL_PM] &&
        term_has(`FC_MOTOR, i_function_codes, i_terminal, 1'b1); // RULE11
    assign fs_no = term_has(`FC_FS_NO, i_function_codes, i_terminal, 1'b1);
    assign fs_nc = term_has(`FC_FS_NC, i_function_codes, i_terminal, 1'b0);
    assign fs_trigger = fs_no || fs_nc || ctrl[`CTRL_FAULT_FS]; // RULE15

    always_comb begin
        pair = 2'd0; // RULE9
        if (term_assigned(`FC_MOTOR, i_function_codes) && !ctrl[`CTRL_PM]) begin
            pair = {motor_in, sel1}; // RULE12
            if (!term_assigned(`FC_SEL1, i_function_codes) &&
                switch_freq != 16'h0) begin
                pair = (o_frequency < switch_freq) ? 2'd3 :
                    (motor_in ? 2'd2 : 2'd0); // RULE13
            end
        end else if (term_assigned(`FC_SEL1, i_function_codes) ||
                     term_assigned(`FC_SEL2, i_function_codes)) begin
            pair = {sel2, sel1}; // RULE10 RULE14
        end else if (switch_freq != 16'h0) begin
            pair = (o_frequency < switch_freq) ? 2'd3 : 2'd0; // RULE13
        end
    end

    assign o_motor2 = motor_in;
    // Coarse unit is ten ticks, so the threshold grows instead of the step
    assign ramp_thr = active_time * (unit_fine ? 32'd1 : 32'd10); // RULE19

    always_comb begin
        target = ctrl[`CTRL_FBL] ? fallback_frequency : // RULE1
            ((i_pid_frequency != 16'h0) ? i_pid_frequency : command);
        if (!ctrl[`CTRL_RUN] || fast_stop) begin
            target = 16'h0;
        end
        if (fast_stop) begin
            active_time = ramp_time[8]; // RULE18
        end else if (target > o_frequency) begin
            active_time = ramp_time[{pair, 1'b0}];
        end else begin
            active_time = ramp_time[{pair, 1'b1}];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fast stop latch and restart interlock
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            fast_stop <= 1'b0;
            fs_decel_done <= 1'b0;
            run_cycled <= 1'b0;
        end else if (fs_trigger && !fast_stop) begin
            fast_stop <= 1'b1; // RULE15
            fs_decel_done <= 1'b0;
            run_cycled <= 1'b0;
        end else if (fast_stop) begin
            if (o_frequency == 16'h0) begin
                fs_decel_done <= 1'b1;
            end
            if (fs_decel_done && !fs_trigger && !ctrl[`CTRL_RUN]) begin
                run_cycled <= 1'b1;
            end
            if (run_cycled && ctrl[`CTRL_RUN]) begin
                fast_stop <= 1'b0; // RULE16
            end
        end
    end

    assign o_fast_stop_terminal = fast_stop &&
        (i_output_function_code == `FC_OUT_FS); // RULE17

    ////////////////////////////////////////////////////////////////////////
    // Ramp engine; rate accumulates max frequency per tick over time
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= ST_IDLE;
            o_frequency <= 16'h0;
            accum <= 32'h0;
            timer <= 32'h0;
        end else if (tick) begin
            case (state)
                ST_IDLE, ST_COAST: begin
                    o_frequency <= 16'h0;
                    timer <= 32'h0;
                    if (ctrl[`CTRL_RUN] && !fast_stop && target != 16'h0) begin
                        state <= ST_ACCEL;
                    end else if (!ctrl[`CTRL_RUN]) begin
                        state <= ST_IDLE;
                    end
                end
                ST_DWELL_UP, ST_DWELL_DN: begin
                    timer <= timer + 32'h1;
                    if (timer >= {16'h0, (state == ST_DWELL_UP ?
                        start_dwell_time :
                        stop_dwell_time)} * 32'd10) begin
                        timer <= 32'h0;
                        state <= (state == ST_DWELL_UP) ? ST_ACCEL : ST_DECEL;
                    end // RULE2 RULE3
                end
                ST_ZHOLD: begin
                    timer <= timer + 32'h1;
                    if (ctrl[`CTRL_RUN] && target != 16'h0 && !fast_stop) begin
                        state <= ST_ACCEL;
                    end else if (zero_hold_time != `HOLD_CONT &&
                        timer >= {16'h0, zero_hold_time}) begin
                        state <= ST_COAST; // RULE7
                    end
                end
                default: begin
                    if (active_time == 32'h0 || o_frequency == target) begin
                        o_frequency <= target;
                        accum <= 32'h0;
                    end else if (accum + {16'h0, max_output_frequency} <
                        ramp_thr) begin
                        accum <= accum + {16'h0, max_output_frequency};
                    end else begin
                        accum <= accum + {16'h0, max_output_frequency} -
                            ramp_thr; // RULE8
                        begin
                            if (target > o_frequency) begin
                                o_frequency <= o_frequency + 16'h1; // RULE23
                            end else begin
                                o_frequency <= o_frequency - 16'h1;
                            end
                        end
                    end
                    if (target > o_frequency) begin
                        state <= ST_ACCEL;
                        if (state != ST_DWELL_UP && start_dwell_time != 16'h0
                            && o_frequency == start_dwell_frequency
                            && o_frequency < target && timer == 32'h0) begin
                            state <= ST_DWELL_UP;
                            timer <= 32'h1;
                        end
                    end else if (target < o_frequency) begin
                        state <= ST_DECEL;
                        if (stop_dwell_time != 16'h0 && target == 16'h0 &&
                            o_frequency == stop_dwell_frequency &&
                            timer == 32'h0) begin
                            state <= ST_DWELL_DN; // RULE3; stopping method not checked for RULE4
                            timer <= 32'h1;
                        end
                    end else if (target == 16'h0) begin
                        timer <= 32'h0;
                        if (ctrl[`CTRL_METHOD_HI:`CTRL_METHOD_LO] <= 3'd1 &&
                            ctrl[`CTRL_RUN] && ctrl[`CTRL_ZH_SEL] &&
                            zero_hold_time != 16'h0 && !fast_stop) begin
                            state <= ST_ZHOLD; // RULE5 RULE6
                        end else begin
                            state <= ST_COAST; // RULE6
                        end
                    end else begin
                        state <= ST_RUN;
                    end
                end
            endcase
        end
    end

    assign o_dc_hold = (state == ST_ZHOLD);
    assign o_dc_hold_current = (i_dc_hold_current >= `DC_HOLD_LIMIT) ?
        (`DC_HOLD_LIMIT - 8'd1) : i_dc_hold_current; // RULE6
    assign o_output_enable = (state != ST_IDLE) && (state != ST_COAST);
endmodule : drive_ramp_time_control
`default_nettype wire

// ==== drive_ramp_checker.sv ====
// Port assertions for the ramp controller
`timescale 1ns/10ps
`default_nettype none
`include "ramp_defs.svh"
module drive_ramp_checker (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [7:0] i_output_function_code,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [15:0] o_frequency,
    input wire logic o_dc_hold,
    input wire logic [7:0] o_dc_hold_current,
    input wire logic o_fast_stop_terminal
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);
    a_fs_flag: assert property (
        o_fast_stop_terminal |-> i_output_function_code == `FC_OUT_FS)
        else $error("fast stop flag without code");
    a_fs_latch: assert property (
        o_fast_stop_terminal && o_frequency != 16'h0 |=> o_fast_stop_terminal)
        else $error("fast stop released while moving");
    a_dc_clamp: assert property (
        o_dc_hold_current < `DC_HOLD_LIMIT)
        else $error("hold current not clamped");
    a_hold_zero: assert property (
        o_dc_hold |-> o_frequency == 16'h0)
        else $error("hold at nonzero frequency");
    a_tick_step: assert property (
        $changed(o_frequency) |=> $stable(o_frequency) [*8])
        else $error("frequency moved between ticks");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken during response");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
endmodule : drive_ramp_checker
////////////////////////////////////////////////////////////////////////////
bind drive_ramp_time_control drive_ramp_checker u_drive_ramp_checker (.*);
`default_nettype wire

// ==== terminal_model.sv ====
// Behavioural model of the multi-function input terminals
`timescale 1ns/10ps
`default_nettype none
module terminal_model (
    input wire logic i_clk,
    input wire logic [1:0] i_sel,
    input wire logic i_stop_req,
    input wire logic i_motor,
    output var logic [3:0] o_terminal = 4'h0,
    output logic [31:0] o_function_codes
);
    assign o_function_codes = 32'h33151110;
    always @(posedge i_clk) begin
        o_terminal <= {i_motor, i_stop_req, i_sel};
    end
endmodule : terminal_model
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the ramp controller
`timescale 1ns/10ps
`default_nettype none
`include "ramp_defs.svh"
module tb;
    localparam int TICK = 10;
    logic i_clk = 1'b0, i_srst = 1'b1, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic stop_req = 1'b0, motor = 1'b0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, o_output_enable;
    logic o_dc_hold, o_fast_stop_terminal, o_motor2;
    logic [1:0] sel = 2'h0, s_axi_bresp, s_axi_rresp, rd_resp;
    logic [3:0] i_terminal, s_axi_wstrb = 4'hf;
    logic [7:0] i_dc_hold_current = 8'h0, i_output_function_code = 8'h2c;
    logic [7:0] o_dc_hold_current;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [15:0] i_pid_frequency = 16'h0, o_frequency;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, i_function_codes, rd_val, v;
    logic [11:0] da [5] = '{`OFS_ACC1, `OFS_FSTOP, `OFS_UNIT, `OFS_FALLBACK,
        `OFS_HOLD};
    logic [31:0] dv [5] = '{32'h64, 32'h64, 32'h1, 32'h12c, 32'ha};
    int acc [4] = '{100, 120, 200, 150};
    int errors = 0, samples_checked = 0, cyc = 0, seed = 64186;
    terminal_model u_terminal_model (.i_clk, .i_sel(sel), .i_stop_req(stop_req),
        .i_motor(motor), .o_terminal(i_terminal), .o_function_codes(i_function_codes));
    drive_ramp_time_control #(.TICK_CYCLES(TICK)) u_drive_ramp_time_control (.*);
    always #2.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        i_dc_hold_current <= 8'($random(seed));
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic int exp_c(int df, int t);
        return df * t * 10 * TICK / 600;
    endfunction : exp_c
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk
    task automatic ramp_to(input logic [15:0] f, input int e);
        int n;
        n = 0;
        while (o_frequency !== f) begin
            @(negedge i_clk);
            n++;
        end
        samples_checked++;
        if (n < e - 20 || n > e + 20) begin
            errors++;
            $display("[ERR] ramp cycles expected %0d seen %0d", e, n);
        end
    endtask : ramp_to
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic done, ta, tw;
        @(posedge i_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(negedge i_clk);
            done = s_axi_bvalid;
            ta = s_axi_awready;
            tw = s_axi_wready;
            @(posedge i_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!done);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        logic done, ta;
        @(posedge i_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge i_clk);
            done = s_axi_rvalid;
            rd_val = s_axi_rdata;
            rd_resp = s_axi_rresp;
            ta = s_axi_arready;
            @(posedge i_clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end while (!done);
    endtask : rd
    task automatic results;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge i_clk);
        i_srst <= 1'b0;
        @(negedge i_clk);
        chk("reset freq", 32'h0, 32'(o_frequency));
        for (int i = 0; i < 5; i++) begin
            rd(da[i]);
            chk("default", dv[i], rd_val);
        end
        rd(12'h050);
        chk("unmapped resp", 32'h2, 32'(rd_resp));
        for (int i = 0; i < 9; i++) begin
            v = {$random(seed)} % 60000;
            wr(12'h004 + 12'(4 * i), v);
            rd(12'h004 + 12'(4 * i));
            chk("ramp time", v, rd_val);
        end
        wr(`OFS_ACC1, 32'h1771);
        wr(`OFS_UNIT, 32'h0);
        rd(`OFS_UNIT);
        chk("unit", 32'h1, rd_val);
        rd(`OFS_STATUS);
        chk("unit refused", 32'h1, 32'(rd_val[`ST_UNIT_REJ]));
        motor <= 1'b1;
        repeat (3) @(posedge i_clk);
        chk("motor2", 32'h1, 32'(o_motor2));
        motor <= 1'b0;
        for (int k = 0; k < 8; k++) wr(12'h004 + 12'(4 * k), acc[k / 2]);
        wr(`OFS_FSTOP, 32'h64);
        wr(`OFS_CTRL, 32'h1);
        for (int k = 0; k < 4; k++) begin
            sel <= 2'(k);
            motor <= 1'(k >> 1);
            wr(`OFS_CMD, 32'(30 * k + 30));
            ramp_to(16'(30 * k + 30), exp_c(30, acc[k]));
        end
        stop_req <= 1'b1;
        @(posedge i_clk);
        stop_req <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk("fast stop out", 32'h1, 32'(o_fast_stop_terminal));
        ramp_to(16'h0, exp_c(120, 100));
        repeat (40) @(negedge i_clk);
        chk("restart held", 32'h0, 32'(o_frequency));
        wr(`OFS_CTRL, 32'h0);
        wr(`OFS_CTRL, 32'h1);
        repeat (100) @(negedge i_clk);
        chk("fast stop clear", 32'h0, 32'(o_fast_stop_terminal));
        wr(`OFS_CMD, 32'h0);
        wr(`OFS_CTRL, 32'h9);
        repeat (600) @(negedge i_clk);
        chk("hold ended", 32'h0, 32'({o_dc_hold, o_output_enable}));
        results();
    end
endmodule : tb
`default_nettype wire
